// File: include/tmr_pkg.sv
/*
 * shared constants of the timer/event counter with tone output:
 * register offsets, control field positions, reset values, mode codes.
 * assumes nothing of its surroundings.
 */
package tmr_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    localparam logic [7:0]  OFF_COUNT     = 8'h0d;  // preload on write, live count on read
    localparam logic [7:0]  OFF_CTRL      = 8'h0e;
    localparam logic [7:0]  OFF_IRQCTL    = 8'h0f;  // overflow flag and irq enable

    // control field positions
    localparam int          MODE_HI       = 7;
    localparam int          MODE_LO       = 6;
    localparam int          CTRL_UNUSED   = 5;
    localparam int          CTRL_EN       = 4;
    localparam int          CTRL_EDGE     = 3;
    localparam int          PSC_HI        = 2;
    localparam int          PSC_LO        = 0;

    // interrupt control field positions
    localparam int          IRQ_FLAG      = 5;
    localparam int          IRQ_EN        = 0;

    localparam logic [7:0]  CTRL_RESET    = 8'h08;
    localparam logic [7:0]  COUNT_RESET   = 8'h00;
    localparam logic [7:0]  COUNT_MAX     = 8'hff;

    typedef enum logic [1:0] {
        MODE_UNUSED = 2'h0,
        MODE_EVENT  = 2'h1,
        MODE_TIMER  = 2'h2,
        MODE_PULSE  = 2'h3
    } mode_t;

endpackage

// File: core/timer_event_counter.sv
/*
 * 8-bit up-counting timer/event counter with preload, 8-step prescaler,
 * pulse-width measurement and a tone output on two buzzer pins.
 * assumes: inputs synchronous to clk_i; a one-cycle register port with
 * read data valid the cycle after the read strobe; port b data latch
 * and direction bits supplied by the surrounding port logic.
 */
`timescale 1ns/1ps

// Behaviour
// - eight-bit up counter clocked by external pin or prescaled system clock.
// - tone frequency is counter clock over two times (256 minus preload).
// - offset 0d writes preload, reads live count; control sits at 0e.
// - mode field 7:6: 01 event, 10 timer, 11 pulse width, 00 unused.
// - event/timer count to ff, reload from preload, set overflow flag together.
// - pulse mode counts from start edge until level returns, then clears enable.
// - finished measurement holds; new one armed only by software setting enable.
// - pulse measurement starts on an edge, never on an existing level.
// - overflow in pulse mode reloads and flags just like other modes.
// - count only with enable bit 4 set; event/timer clear only by software.
// - counter overflow raises a wake-up request.
// - irq enable zero blocks interrupt service; flag may still set.
// - preload write while stopped also loads counter; while running only preload.
// - counting clock blocked during a count read; lost counts not made up.
// - prescale field 2:0 divides system clock by two to the field plus one.
// - event mode edge bit 1 counts falling edges, 0 rising edges.
// - pulse mode edge bit 1 measures high pulse, 0 measures low pulse.
// - buzzer option drives tone on port b pins 0 and 1 when outputs.
// - port b bit zero latch alone gates both buzzer outputs.
// - buzzer use is a fixed build option, not a register.
module timer_event_counter
    import tmr_pkg::*;
#(
    parameter bit BUZZER_EN = 1'b1                      // fixed buzzer option
) (
    input  wire logic                  clk_i,           // system clock, 250 MHz
    input  wire logic                  rst_n_i,         // async reset, active low
    input  wire logic [tmr_pkg::ADDR_W-1:0] addr_i,     // register address
    input  wire logic [tmr_pkg::DATA_W-1:0] wdata_i,    // write data
    input  wire logic                  wr_i,            // write strobe
    input  wire logic                  rd_i,            // read strobe
    output logic      [tmr_pkg::DATA_W-1:0] rdata_o,    // read data, cycle after rd_i
    input  wire logic                  timer_pin_i,     // external event / pulse input
    input  wire logic                  pb0_latch_i,     // port b bit 0 data latch
    input  wire logic                  pb1_latch_i,     // port b bit 1 data latch
    input  wire logic                  pb0_out_en_i,    // port b bit 0 is output
    input  wire logic                  pb1_out_en_i,    // port b bit 1 is output
    output logic                       pb0_pad_o,       // pin level when driven
    output logic                       pb0_oe_o,        // pin 0 driven
    output logic                       pb1_pad_o,       // pin level when driven
    output logic                       pb1_oe_o,        // pin 1 driven
    output logic                       irq_o,           // interrupt request, level
    output logic                       wake_o           // wake-up pulse on overflow
);
    import tmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] count_q, count_d;
    logic [7:0] preload_q;
    logic [7:0] ctrl_q;
    logic       flag_q, irq_en_q;
    logic [7:0] psc_q;
    logic       pin_q;
    logic       meas_q;          // pulse measurement running
    logic       tone_q;
    logic [7:0] rdata_q;
    logic       irq_q, wake_q;
    logic       pb0_pad_q, pb0_oe_q, pb1_pad_q, pb1_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire        wr_count  = wr_i && (addr_i == OFF_COUNT);
    wire        wr_ctrl   = wr_i && (addr_i == OFF_CTRL);
    wire        wr_irq    = wr_i && (addr_i == OFF_IRQCTL);
    wire        rd_count  = rd_i && (addr_i == OFF_COUNT);
    wire [1:0]  mode      = ctrl_q[MODE_HI:MODE_LO];
    wire        enabled   = ctrl_q[CTRL_EN];
    wire        edge_sel  = ctrl_q[CTRL_EDGE];
    wire [2:0]  psc_sel   = ctrl_q[PSC_HI:PSC_LO];

    // prescaler: one tick per 2^(sel+1) system clocks
    wire [7:0]  psc_mask  = 8'(({1'b0, 8'hff} >> (4'd7 - {1'b0, psc_sel})));
    wire        int_tick  = (psc_q & psc_mask) == psc_mask;

    // edges of the external pin
    wire        rise      = timer_pin_i && !pin_q;
    wire        fall      = !timer_pin_i && pin_q;
    wire        ev_edge   = edge_sel ? fall : rise;
    wire        start_edg = edge_sel ? rise : fall;
    wire        stop_edg  = edge_sel ? fall : rise;

    // count clock per mode; blocked while software reads the count
    wire        mode_tick = (mode == MODE_EVENT) ? ev_edge :
                            (mode == MODE_TIMER) ? int_tick :
                            (mode == MODE_PULSE) ? (meas_q && int_tick) : 1'b0;
    wire        do_count  = enabled && mode_tick && !rd_count;
    wire        overflow  = do_count && (count_q == COUNT_MAX);
    wire        meas_done = (mode == MODE_PULSE) && enabled && meas_q && stop_edg;
    wire        meas_go   = (mode == MODE_PULSE) && enabled && !meas_q && start_edg;

    // next count value
    always_comb begin
        count_d = count_q;
        if (overflow)
            count_d = preload_q;
        else if (do_count)
            count_d = count_q + 8'h01;
        if (wr_count && !enabled)
            count_d = wdata_i;
    end

    // read mux, unmapped reads as zero
    wire [7:0]  ctrl_rd   = ctrl_q & ~(8'h01 << CTRL_UNUSED);
    wire [7:0]  irq_rd    = (8'(flag_q) << IRQ_FLAG) | (8'(irq_en_q) << IRQ_EN);
    wire [7:0]  rd_mux    = (addr_i == OFF_COUNT)  ? count_q :
                            (addr_i == OFF_CTRL)   ? ctrl_rd :
                            (addr_i == OFF_IRQCTL) ? irq_rd  : 8'h00;

    // buzzer: pin 0 latch gates both, pin 1 is the complement
    wire        bz_on     = BUZZER_EN && pb0_latch_i;
    wire        pb0_lvl   = BUZZER_EN ? (bz_on & tone_q) : pb0_latch_i;
    wire        pb1_lvl   = BUZZER_EN ? (bz_on & ~tone_q) : pb1_latch_i;
    wire        tone_d    = overflow ? ~tone_q : tone_q;

    ////////////////////////////////////////////////////////////////////////////
    // counter and preload
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q   <= COUNT_RESET;
            preload_q <= COUNT_RESET;
        end else begin
            count_q   <= count_d;
            if (wr_count)
                preload_q <= wdata_i;
        end
    end

    // control: hardware clear of enable ends a measurement
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= wdata_i;
        end else if (meas_done) begin
            ctrl_q[CTRL_EN] <= 1'b0;
        end
    end

    // measurement state; a write to control re-arms and forgets the old edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            meas_q <= 1'b0;
        else if (wr_ctrl || meas_done)
            meas_q <= 1'b0;
        else if (meas_go)
            meas_q <= 1'b1;
    end

    // prescaler and pin history
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            psc_q <= 8'h00;
            pin_q <= 1'b0;
        end else begin
            psc_q <= psc_q + 8'h01;
            pin_q <= timer_pin_i;
        end
    end

    // overflow flag: set wins over a software clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_q   <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (overflow)
                flag_q <= 1'b1;
            else if (wr_irq)
                flag_q <= wdata_i[IRQ_FLAG];
            if (wr_irq)
                irq_en_q <= wdata_i[IRQ_EN];
        end
    end

    // registered outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tone_q    <= 1'b0;
            rdata_q   <= 8'h00;
            irq_q     <= 1'b0;
            wake_q    <= 1'b0;
            pb0_pad_q <= 1'b0;
            pb0_oe_q  <= 1'b0;
            pb1_pad_q <= 1'b0;
            pb1_oe_q  <= 1'b0;
        end else begin
            tone_q    <= tone_d;
            rdata_q   <= rd_i ? rd_mux : 8'h00;
            irq_q     <= (flag_q || overflow) && irq_en_q;
            wake_q    <= overflow;
            pb0_pad_q <= pb0_lvl;
            pb0_oe_q  <= pb0_out_en_i;
            pb1_pad_q <= pb1_lvl;
            pb1_oe_q  <= pb1_out_en_i;
        end
    end

    assign rdata_o   = rdata_q;
    assign irq_o     = irq_q;
    assign wake_o    = wake_q;
    assign pb0_pad_o = pb0_pad_q;
    assign pb0_oe_o  = pb0_oe_q;
    assign pb1_pad_o = pb1_pad_q;
    assign pb1_oe_o  = pb1_oe_q;

endmodule // timer_event_counter

// File: sim/tmr_monitor.sv
/* port checker of the timer/event counter; assumes one clock and the buzzer option on. */
`timescale 1ns/1ps
module tmr_check
    import tmr_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       pb0_latch_i,
    input wire logic       pb0_pad_o,
    input wire logic       pb1_pad_o,
    input wire logic       wake_o,
    input wire logic       irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_irq_off;
        wr_i && addr_i == OFF_IRQCTL && !wdata_i[IRQ_EN];
    endsequence
    a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("rdata not zero");
    a_hole_zero: assert property (rd_i && addr_i > OFF_IRQCTL |=> rdata_o == 8'h00) else $error("hole read");
    a_spare_zero: assert property (rd_i && addr_i == OFF_CTRL |=> !rdata_o[CTRL_UNUSED]) else $error("bit5 set");
    a_gate_low: assert property (!pb0_latch_i |=> !pb0_pad_o && !pb1_pad_o) else $error("pad not gated");
    a_pair_diff: assert property (pb0_latch_i |=> pb0_pad_o != pb1_pad_o) else $error("pads equal");
    a_wake_once: assert property (wake_o |=> !wake_o) else $error("wake too long");
    a_tone_flip: assert property (wake_o && pb0_latch_i && $past(pb0_latch_i) |=> $changed(pb0_pad_o))
        else $error("tone held");
    a_irq_mask: assert property (s_irq_off ##1 !(wr_i && addr_i == OFF_IRQCTL) |=> !irq_o) else $error("irq on");
endmodule // tmr_check
////////////////////////////////////////
bind timer_event_counter tmr_check tmr_check_inst (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .pb0_latch_i, .pb0_pad_o, .pb1_pad_o, .wake_o, .irq_o);

// File: sim/pin_source.sv
/* pulse source on the timer pin; a driven line that is never released. */
`timescale 1ns/1ps
module pin_source (
    input  wire logic clk_i,  // system clock
    output logic      pin_o   // timer pin level
);
    initial pin_o = 1'b0;
    task automatic pulses(input int n, w);
        repeat (n) begin
            @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (w) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (w) @(posedge clk_i);
        end
    endtask
endmodule // pin_source

// File: sim/tb_timer_event_counter.sv
/* bench of the timer/event counter; assumes pin_source on the timer pin. */
`timescale 1ns/1ps
module tb_timer_event_counter;
    import tmr_pkg::*;
    logic        clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rd_q = 0, lat0 = 0, oe = 1, pin, irq;
    logic [7:0]  addr_i = 0, wdata_i = 0, rdata_o, v;
    logic [15:0] exp_q[$];
    int          n_fail = 0, checked = 0, i, seed = 32'h337c;
    always #2 clk_i = ~clk_i;
    timer_event_counter timer_event_counter_inst (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .timer_pin_i(pin), .pb0_latch_i(lat0), .pb1_latch_i(oe), .pb0_out_en_i(oe), .pb1_out_en_i(oe),
        .pb0_pad_o(), .pb0_oe_o(), .pb1_pad_o(), .pb1_oe_o(), .irq_o(irq), .wake_o());
    pin_source pin_source_inst (.clk_i, .pin_o(pin));
    task automatic bus(input logic we, input logic [7:0] a, d, lo, hi);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= we;
        rd_i <= !we;
        if (!we) exp_q.push_back({lo, hi});
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [15:0] e);
        checked++;
        if (got inside {[e[15:8]:e[7:0]]}) return;
        n_fail++;
        $display("[FAIL] %0t got %h want %h..%h", $time, got, e[15:8], e[7:0]);
    endtask
    always @(posedge clk_i) begin
        rd_q <= rd_i;
        if (rd_q) chk(rdata_o, exp_q.pop_front());
    end
    task automatic give_verdict(input int extra);
        $display("checked %0d n_fail %0d", checked, n_fail + extra);
        if (n_fail + extra == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial #20000 give_verdict(1);
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        bus(1, OFF_CTRL, 8'h2f, 0, 0);
        bus(0, OFF_CTRL, 0, 8'h0f, 8'h0f);
        bus(0, 8'h3c, 0, 0, 0);
        v = 8'($random(seed)) & 8'h7f;
        bus(1, OFF_COUNT, v, 0, 0);
        bus(0, OFF_COUNT, 0, v, v);
        bus(1, OFF_CTRL, 8'h50, 0, 0);
        pin_source_inst.pulses(3, 2);
        bus(0, OFF_COUNT, 0, v + 8'h03, v + 8'h03);
        bus(1, OFF_COUNT, 8'h80, 0, 0);
        bus(1, OFF_CTRL, 8'h58, 0, 0);
        pin_source_inst.pulses(3, 2);
        bus(0, OFF_COUNT, 0, v + 8'h06, v + 8'h06);
        bus(1, OFF_CTRL, 8'h00, 0, 0);
        bus(1, OFF_COUNT, 8'hfd, 0, 0);
        bus(1, OFF_IRQCTL, 8'h01, 0, 0);
        lat0 <= 1'b1;
        bus(1, OFF_CTRL, 8'h90, 0, 0);
        for (i = 0; i < 40 && irq !== 1'b1; i++) @(negedge clk_i);
        chk({7'h00, irq}, 16'h0101);
        bus(0, OFF_IRQCTL, 0, 8'h21, 8'h21);
        bus(1, OFF_IRQCTL, 8'h00, 0, 0);
        bus(1, OFF_CTRL, 8'h00, 0, 0);
        bus(1, OFF_COUNT, 8'h00, 0, 0);
        bus(1, OFF_CTRL, 8'hd1, 0, 0);
        bus(0, OFF_COUNT, 0, 0, 0);
        pin_source_inst.pulses(2, 24);
        bus(0, OFF_CTRL, 0, 8'hc1, 8'hc1);
        bus(0, OFF_COUNT, 0, 8'h05, 8'h07);
        give_verdict(0);
    end
endmodule // tb_timer_event_counter
